// ===== phy_10bt_bist_diag_regs.sv
/*
 APB register bank for 10Base-T control, packet self-test settings and
 cable diagnostics of a 10/100 transceiver.
 Assumes event inputs come from core logic on pclk, single-cycle pulses.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "phy_regs_defines.svh"

module phy_10bt_bist_diag_regs
    import phy_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic polarity_inverted_event,
    input wire logic checker_err_byte,
    input wire logic checker_count_mode,
    input wire logic selftest_ctrl_lock,
    input wire logic diag_done_event,
    input wire logic diag_result_fail,
    input wire logic [1:0] diag_link_quality,
    output logic rx_low_threshold,
    output logic [3:0] squelch_level,
    output logic normal_link_pulse_disable,
    output logic jabber_disable,
    output logic polarity_flag,
    output logic [7:0] ipg_length,
    output logic [10:0] packet_length,
    output logic diag_start
);

    // true when the word address matches a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
    endfunction

    logic [3:0] squelch_field;
    logic [7:0] err_counter;
    logic [7:0] err_shown;
    logic err_frozen;
    logic diag_done;
    logic diag_fail;
    link_quality_e link_quality;

    logic next_rx_low_threshold;
    logic [3:0] next_squelch_field;
    logic [3:0] next_squelch_level;
    logic next_nlp_disable;
    logic next_jabber_disable;
    logic next_polarity_flag;
    logic [7:0] next_err_counter;
    logic [7:0] next_err_shown;
    logic next_err_frozen;
    logic [7:0] next_ipg_length;
    logic [10:0] next_packet_length;
    logic next_diag_start;
    logic next_diag_done;
    logic next_diag_fail;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // completing access phase, the only edge where a write lands
    logic xfer;
    logic wr;
    logic rd;
    logic hit_tenbt;
    logic hit_errgap;
    logic hit_pktlen;
    logic hit_diag;
    logic mapped;
    logic cnt_latch_wr;
    logic count_lock;
    logic diag_start_wr;
    reg16_t rd_word;

    assign xfer = psel & penable & pready;
    assign wr = xfer & pwrite;
    assign rd = xfer & ~pwrite;
    assign hit_tenbt = hit(paddr, `IDX_TENBT_CTRL);
    assign hit_errgap = hit(paddr, `IDX_ERRCNT_GAP);
    assign hit_pktlen = hit(paddr, `IDX_PKT_LEN);
    assign hit_diag = hit(paddr, `IDX_DIAG);
    assign mapped = hit_tenbt | hit_errgap | hit_pktlen | hit_diag;
    assign cnt_latch_wr = wr & hit_errgap & pwdata[`BIT_CNT_LATCH];
    assign count_lock = cnt_latch_wr | selftest_ctrl_lock;
    assign diag_start_wr = wr & hit_diag & pwdata[`BIT_DIAG_START];

    // read mux, reserved positions stay zero
    always_comb begin
        rd_word = '0;
        if (hit_tenbt) begin
            rd_word[`BIT_RX_LOW_TH] = rx_low_threshold;
            rd_word[`SQ_MSB:`SQ_LSB] = squelch_field;
            rd_word[`BIT_NLP_DIS] = normal_link_pulse_disable;
            rd_word[`BIT_POLARITY] = polarity_flag;
            rd_word[`BIT_JABBER_DIS] = jabber_disable;
        end else if (hit_errgap) begin
            rd_word[`ERR_MSB:`ERR_LSB] = err_frozen ? err_shown : err_counter;
            rd_word[`IPG_MSB:`IPG_LSB] = ipg_length;
        end else if (hit_pktlen) begin
            rd_word[`PKT_MSB:`PKT_LSB] = packet_length;
        end else if (hit_diag) begin
            rd_word[`BIT_DIAG_START] = diag_start;
            rd_word[`LQ_MSB:`LQ_LSB] = link_quality;
            rd_word[`BIT_DIAG_DONE] = diag_done;
            rd_word[`BIT_DIAG_FAIL] = diag_fail;
        end
    end

    // next state of bus answer and every register but link_quality
    always_comb begin
        // one wait cycle in every access keeps prdata a flop output
        next_pready = psel & penable & ~pready;
        next_prdata = next_pready ? {16'h0000, rd_word} : '0;
        next_pslverr = next_pready & ~mapped;

        next_rx_low_threshold = rx_low_threshold;
        next_squelch_field = squelch_field;
        next_nlp_disable = normal_link_pulse_disable;
        next_jabber_disable = jabber_disable;
        next_ipg_length = ipg_length;
        next_packet_length = packet_length;
        if (wr && hit_tenbt) begin
            next_rx_low_threshold = pwdata[`BIT_RX_LOW_TH];
            next_squelch_field = pwdata[`SQ_MSB:`SQ_LSB];
            next_nlp_disable = pwdata[`BIT_NLP_DIS];
            next_jabber_disable = pwdata[`BIT_JABBER_DIS];
        end
        if (wr && hit_errgap) begin
            next_ipg_length = pwdata[`IPG_MSB:`IPG_LSB];
        end
        if (wr && hit_pktlen) begin
            next_packet_length = pwdata[`PKT_MSB:`PKT_LSB];
        end

        next_squelch_level = (next_squelch_field > `SQ_MAX_CODE) ? `SQ_MAX_CODE :
            next_squelch_field;

        // clear on read here, new event wins
        next_polarity_flag = polarity_flag;
        if (rd && hit_tenbt) begin
            next_polarity_flag = 1'b0;
        end
        if (polarity_inverted_event) begin
            next_polarity_flag = 1'b1;
        end

        next_err_counter = err_counter;
        if (checker_err_byte) begin
            if (checker_count_mode || err_counter != `ERR_MAX) begin
                next_err_counter = err_counter + 8'h01;
            end
        end
        if (cnt_latch_wr) begin
            next_err_counter = checker_err_byte ? 8'h01 : 8'h00;
        end
        next_err_shown = err_shown;
        next_err_frozen = err_frozen;
        if (count_lock) begin
            next_err_shown = err_counter;
            next_err_frozen = 1'b1;
        end

        // done clears start, a fresh start write wins
        next_diag_start = diag_start;
        next_diag_done = diag_done;
        next_diag_fail = diag_fail;
        if (diag_done_event) begin
            next_diag_start = 1'b0;
            next_diag_done = 1'b1;
            next_diag_fail = diag_result_fail;
        end
        if (wr && hit_diag) begin
            next_diag_start = pwdata[`BIT_DIAG_START];
        end
        if (diag_start_wr) begin
            // new run forgets old result
            next_diag_done = 1'b0;
            next_diag_fail = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rx_low_threshold <= 1'b0;
            squelch_field <= 4'h0;
            squelch_level <= 4'h0;
            normal_link_pulse_disable <= 1'b0;
            jabber_disable <= 1'b0;
            polarity_flag <= 1'b0;
            err_counter <= 8'h00;
            err_shown <= 8'h00;
            err_frozen <= 1'b0;
            ipg_length <= `IPG_RESET;
            packet_length <= `PKT_RESET;
            diag_start <= 1'b0;
            diag_done <= 1'b0;
            diag_fail <= 1'b0;
            link_quality <= lq_reserved;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            rx_low_threshold <= next_rx_low_threshold;
            squelch_field <= next_squelch_field;
            squelch_level <= next_squelch_level;
            normal_link_pulse_disable <= next_nlp_disable;
            jabber_disable <= next_jabber_disable;
            polarity_flag <= next_polarity_flag;
            err_counter <= next_err_counter;
            err_shown <= next_err_shown;
            err_frozen <= next_err_frozen;
            ipg_length <= next_ipg_length;
            packet_length <= next_packet_length;
            diag_start <= next_diag_start;
            diag_done <= next_diag_done;
            diag_fail <= next_diag_fail;
            // quality only meaningful while link is up, caller decides
            link_quality <= link_quality_e'(diag_link_quality);
        end
    end

    // checks on the bank
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_tenbt_write;
        wr && hit_tenbt;
    endsequence

    sequence s_diag_start_write;
        diag_start_wr;
    endsequence

    sequence s_done_only;
        diag_done_event && !(wr && hit_diag);
    endsequence

    a_rsvd_read_zero: assert property (
        pready && !pwrite && hit_tenbt |-> (prdata[15:0] & ~`TENBT_USED_MASK) == 16'h0000)
        else $error("reserved bit read as one");

    a_thresh_follows: assert property (
        s_tenbt_write |=> rx_low_threshold == $past(pwdata[`BIT_RX_LOW_TH]))
        else $error("receive threshold not written");

    a_squelch_apply: assert property (
        s_tenbt_write ##1 (squelch_field <= `SQ_MAX_CODE) |-> squelch_level == squelch_field)
        else $error("squelch code not applied");

    a_squelch_clamp: assert property (
        squelch_field > `SQ_MAX_CODE |-> squelch_level == `SQ_MAX_CODE)
        else $error("squelch above maximum");

    a_nlp_follow: assert property (
        s_tenbt_write |=> normal_link_pulse_disable == $past(pwdata[`BIT_NLP_DIS]))
        else $error("link pulse disable not written");

    a_jabber_follow: assert property (
        s_tenbt_write |=> jabber_disable == $past(pwdata[`BIT_JABBER_DIS]))
        else $error("jabber disable not written");

    a_pol_set: assert property (
        polarity_inverted_event |=> polarity_flag)
        else $error("polarity event lost");

    a_pol_read_clear: assert property (
        rd && hit_tenbt && !polarity_inverted_event |=> !polarity_flag)
        else $error("polarity not cleared by read");

    a_pol_holds: assert property (
        polarity_flag && !(rd && hit_tenbt) |=> polarity_flag)
        else $error("polarity cleared without read");

    a_cnt_step: assert property (
        checker_err_byte && !cnt_latch_wr && err_counter != `ERR_MAX
            |=> err_counter == $past(err_counter) + 8'h01)
        else $error("error byte not counted");

    a_cnt_saturate: assert property (
        !checker_count_mode && err_counter == `ERR_MAX && !cnt_latch_wr
            |=> err_counter == `ERR_MAX)
        else $error("counter wrapped in saturate mode");

    a_cnt_freeze: assert property (
        count_lock |=> err_frozen && err_shown == $past(err_counter))
        else $error("count not frozen");

    a_cnt_clear: assert property (
        cnt_latch_wr && !checker_err_byte |=> err_counter == 8'h00)
        else $error("counter not cleared");

    a_gap_write: assert property (
        wr && hit_errgap |=> ipg_length == $past(pwdata[`IPG_MSB:`IPG_LSB]))
        else $error("gap not written");

    a_len_write: assert property (
        wr && hit_pktlen |=> packet_length == $past(pwdata[`PKT_MSB:`PKT_LSB]))
        else $error("length not written");

    a_diag_starts: assert property (
        s_diag_start_write |=> diag_start && !diag_done)
        else $error("diagnostic not started");

    a_done_clears_start: assert property (
        s_done_only |=> !diag_start && diag_done)
        else $error("start not cleared at done");

    a_fail_capture: assert property (
        s_done_only |=> diag_fail == $past(diag_result_fail))
        else $error("fail result not captured");

    a_quality_read: assert property (
        rd && hit_diag |-> prdata[`LQ_MSB:`LQ_LSB] == $past(link_quality))
        else $error("link quality misread");

    a_access_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one wait cycle");

endmodule

// ===== phy_regs_defines.svh
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH
/*
 Register indices, field positions, reset values and limits of the
 10Base-T, self-test and cable diagnostic register bank.
 Assumes APB byte address = 4 * register index.
*/
// register indices, byte address is four times these
`define IDX_TENBT_CTRL 6'h1a
`define IDX_ERRCNT_GAP 6'h1b
`define IDX_PKT_LEN 6'h1c
`define IDX_DIAG 6'h1e
// 10Base-T status/control fields
`define BIT_RX_LOW_TH 13
`define SQ_MSB 12
`define SQ_LSB 9
`define BIT_NLP_DIS 7
`define BIT_POLARITY 4
`define BIT_JABBER_DIS 0
`define SQ_MAX_CODE 4'h8
`define TENBT_USED_MASK 16'h3e91
// self-test fields
`define BIT_CNT_LATCH 15
`define ERR_MSB 15
`define ERR_LSB 8
`define IPG_MSB 7
`define IPG_LSB 0
`define IPG_RESET 8'h7d
`define ERR_MAX 8'hff
`define PKT_MSB 10
`define PKT_LSB 0
`define PKT_RESET 11'h5dc
// cable diagnostic fields
`define BIT_DIAG_START 15
`define LQ_MSB 9
`define LQ_LSB 8
`define BIT_DIAG_DONE 1
`define BIT_DIAG_FAIL 0
`endif

// ===== phy_regs_pkg.sv
/*
 Types shared by the register bank.
 Assumes the defines header is compiled alongside.
*/
package phy_regs_pkg;
    typedef logic [15:0] reg16_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        lq_reserved = 2'b00,
        lq_good = 2'b01,
        lq_medium = 2'b10,
        lq_poor = 2'b11
    } link_quality_e;
endpackage

// ===== tb_top.sv
/*
 Self-checking testbench for the 10Base-T, self-test and cable
 diagnostic register bank, driven over APB.
 Assumes the defines header and the package are compiled first.
*/
`timescale 1ns/1ps
`include "phy_regs_defines.svh"

module tb_top
    import phy_regs_pkg::*;
;
    localparam logic [7:0] addr_tenbt = {`IDX_TENBT_CTRL, 2'b00};
    localparam logic [7:0] addr_gap = {`IDX_ERRCNT_GAP, 2'b00};
    localparam logic [7:0] addr_pkt = {`IDX_PKT_LEN, 2'b00};
    localparam logic [7:0] addr_diag = {`IDX_DIAG, 2'b00};

    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } row_s;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic polarity_inverted_event = 1'b0;
    logic checker_err_byte = 1'b0;
    logic checker_count_mode = 1'b0;
    logic selftest_ctrl_lock = 1'b0;
    logic diag_done_event = 1'b0;
    logic diag_result_fail = 1'b0;
    logic [1:0] diag_link_quality = 2'b00;
    logic rx_low_threshold;
    logic [3:0] squelch_level;
    logic normal_link_pulse_disable;
    logic jabber_disable;
    logic polarity_flag;
    logic [7:0] ipg_length;
    logic [10:0] packet_length;
    logic diag_start;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    // ordinary accesses: reserved bits, read-only bits, unmapped places
    row_s rows [0:6] = '{
        '{addr_tenbt, 32'h0000_ffff, 32'h0000_3e81, 1'b0},
        '{addr_tenbt, 32'h0000_2091, 32'h0000_2081, 1'b0},
        '{8'h69, 32'h0000_ffff, 32'h0, 1'b1},
        '{8'h74, 32'h0000_ffff, 32'h0, 1'b1},
        '{addr_gap, 32'h0000_00a5, 32'h0000_00a5, 1'b0},
        '{addr_pkt, 32'hffff_ffff, 32'h0000_07ff, 1'b0},
        '{addr_diag, 32'h0000_7fff, 32'h0, 1'b0}
    };

    // 100 MHz clock
    always #5 pclk = ~pclk;

    phy_10bt_bist_diag_regs #(.ADDR_W(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .polarity_inverted_event(polarity_inverted_event),
        .checker_err_byte(checker_err_byte),
        .checker_count_mode(checker_count_mode),
        .selftest_ctrl_lock(selftest_ctrl_lock),
        .diag_done_event(diag_done_event), .diag_result_fail(diag_result_fail),
        .diag_link_quality(diag_link_quality), .rx_low_threshold(rx_low_threshold),
        .squelch_level(squelch_level),
        .normal_link_pulse_disable(normal_link_pulse_disable),
        .jabber_disable(jabber_disable), .polarity_flag(polarity_flag),
        .ipg_length(ipg_length), .packet_length(packet_length),
        .diag_start(diag_start)
    );

    task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one APB transfer; waits on pready, never on a fixed count
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        if (w >= 16) begin
            n_fail++;
            $display("CHECK FAILED pready expected 1 seen 0");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        repeat (2) @(negedge pclk);
    endtask

    task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check_val(what, exp, r);
        @(negedge pclk);
    endtask

    // one-cycle event pulses: 0 polarity, 1 error byte, 2 lock, 3 done
    task pulse(input int which, input int n);
        repeat (n) begin
            @(posedge pclk);
            case (which)
                0: polarity_inverted_event <= 1'b1;
                1: checker_err_byte <= 1'b1;
                2: selftest_ctrl_lock <= 1'b1;
                default: diag_done_event <= 1'b1;
            endcase
            @(posedge pclk);
            polarity_inverted_event <= 1'b0;
            checker_err_byte <= 1'b0;
            selftest_ctrl_lock <= 1'b0;
            diag_done_event <= 1'b0;
        end
        @(negedge pclk);
    endtask

    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            $display("CHECK FAILED run length expected below 20000 seen 20000");
            results();
        end
    end

    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [1:0] prev_q;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check_val("ipg_length", 32'h7d, 32'(ipg_length));
        check_val("packet_length", 32'h5dc, 32'(packet_length));
        check_val("control outputs", 32'h0, 32'({rx_low_threshold, squelch_level,
            normal_link_pulse_disable, jabber_disable, polarity_flag, diag_start}));
        rdc("tenbt reset", addr_tenbt, 32'h0);
        rdc("gap reset", addr_gap, 32'h7d);
        rdc("length reset", addr_pkt, 32'h5dc);
        rdc("diag reset", addr_diag, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, r, e);
            check_val("write error", 32'(rows[i].err), 32'(e));
            apb(1'b0, rows[i].addr, 32'h0, r, e);
            check_val("read data", rows[i].rdata, r);
            check_val("read error", 32'(rows[i].err), 32'(e));
        end
        check_val("rx threshold", 32'h1, 32'(rx_low_threshold));
        check_val("link pulse off", 32'h1, 32'(normal_link_pulse_disable));
        check_val("jabber off", 32'h1, 32'(jabber_disable));
        check_val("gap out", 32'ha5, 32'(ipg_length));
        check_val("length out", 32'h7ff, 32'(packet_length));
        rdc("tenbt kept", addr_tenbt, 32'h2081);
        $display("test table done");
        // read clears the flag, the reread shows it low
        pulse(0, 1);
        check_val("polarity set", 32'h1, 32'(polarity_flag));
        rdc("polarity read", addr_tenbt, 32'h2091);
        check_val("polarity cleared", 32'h0, 32'(polarity_flag));
        rdc("polarity reread", addr_tenbt, 32'h2081);
        $display("test polarity done");
        for (int c = 0; c < 16; c++) begin
            wr(addr_tenbt, 32'(c << 9));
            check_val("squelch applied", 32'((c > 8) ? 8 : c), 32'(squelch_level));
            rdc("squelch field", addr_tenbt, 32'(c << 9));
        end
        $display("test squelch done");
        // a lock first, so the shown count is always a snapshot
        pulse(2, 1);
        wr(addr_gap, 32'h807d);
        pulse(1, 260);
        rdc("count frozen", addr_gap, 32'h007d);
        wr(addr_gap, 32'h807d);
        rdc("count saturated", addr_gap, 32'hff7d);
        pulse(1, 3);
        rdc("count latched", addr_gap, 32'hff7d);
        pulse(2, 1);
        rdc("count after lock", addr_gap, 32'h037d);
        @(posedge pclk);
        checker_count_mode <= 1'b1;
        wr(addr_gap, 32'h807d);
        pulse(1, 257);
        wr(addr_gap, 32'h807d);
        rdc("count wrapped", addr_gap, 32'h017d);
        $display("test error count done");
        prev_q = 2'b00;
        for (int q = lq_good; q <= lq_poor; q++) begin
            wr(addr_diag, 32'h8000);
            check_val("diag start", 32'h1, 32'(diag_start));
            rdc("diag running", addr_diag, 32'h8000 | 32'(prev_q) << 8);
            @(posedge pclk);
            diag_link_quality <= 2'(q);
            diag_result_fail <= (q == lq_poor);
            pulse(3, 1);
            check_val("diag start clear", 32'h0, 32'(diag_start));
            rdc("diag result", addr_diag, (32'(q) << 8) | 32'h2 | 32'(q == lq_poor));
            prev_q = 2'(q);
        end
        $display("test diagnostic done");
        // mid-run reset must bring every register back to its reset value, except link quality, which follows diag_link_quality
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check_val("gap after reset", 32'h7d, 32'(ipg_length));
        check_val("length after reset", 32'h5dc, 32'(packet_length));
        check_val("start after reset", 32'h0, 32'(diag_start));
        rdc("tenbt after reset", addr_tenbt, 32'h0);
        rdc("diag after reset", addr_diag, 32'h0000_0300);
        $display("test mid-run reset done");
        results();
    end
endmodule
